// ===== tpwm_pkg.sv
`default_nettype none
// Shared register map, field layout and reset values of the compare/PWM timer.
package tpwm_pkg;
   // Register byte offsets on the APB port.
   localparam logic [7:0] TCTRL_OFS = 8'h00;
   localparam logic [7:0] COUNT_OFS = 8'h04;
   localparam logic [7:0] PERIOD_OFS = 8'h08;
   localparam logic [7:0] C0CTRL_OFS = 8'h0C;
   localparam logic [7:0] C0CMP_OFS = 8'h10;
   localparam logic [7:0] C1CTRL_OFS = 8'h14;
   localparam logic [7:0] C1CMP_OFS = 8'h18;
   localparam logic [7:0] LINK_OFS = 8'h1C;
   // Timer control and status fields.
   localparam int HALT_BIT = 0;
   localparam int CLR_BIT = 1;
   localparam int PS_LSB = 2;
   localparam int TOIE_BIT = 6;
   localparam int TOF_BIT = 7;
   // Channel control and status fields.
   localparam int TOR_BIT = 0;
   localparam int FULL_BIT = 1;
   localparam int ACT_LSB = 2;
   localparam int MODE_LSB = 4;
   localparam int CIE_BIT = 6;
   localparam int CHF_BIT = 7;
   // Field encodings.
   localparam logic [1:0] ACT_TOGGLE = 2'h1;
   localparam logic [1:0] ACT_CLEAR = 2'h2;
   localparam logic [1:0] ACT_SET = 2'h3;
   localparam logic [1:0] MODE_OFF = 2'h0;
   localparam logic [1:0] MODE_UNBUF = 2'h1;
   localparam logic [2:0] PS_LAST = 3'h6;
   // Reset values.
   localparam logic [15:0] PERIOD_RST = 16'hFFFF;
   localparam logic [15:0] COUNT_RST = 16'h0000;
endpackage
`default_nettype wire

// ===== tpwm_prescale.sv
`timescale 1ns/1ps
`default_nettype none
// Divides the bus clock by a power of two and issues one-cycle timer ticks.
module tpwm_prescale #(
   parameter int PRE_W = 6
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic halt,
   input wire logic clear,
   input wire logic [2:0] sel,
   output logic tick
);
   typedef struct packed {
      logic [PRE_W-1:0] cnt;
   } pre_state_type;

   pre_state_type s_r;
   pre_state_type s_nxt;
   logic [PRE_W-1:0] mask;

   // Low bits of the divider that must all be ones for a tick.
   assign mask = PRE_W'((1 << sel) - 1);
   // Code seven selects no source, so the counter gets no ticks.
   assign tick = !halt && !clear && (sel <= tpwm_pkg::PS_LAST)
                 && ((s_r.cnt & mask) == mask);

   // Free-running divider, cleared together with the timer counter.
   always_comb begin
      s_nxt = s_r;
      if (clear) begin
         s_nxt.cnt = '0;
      end else if (!halt) begin
         s_nxt.cnt = s_r.cnt + PRE_W'(1);
      end
   end

   // Registers the divider state.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end
endmodule
`default_nettype wire

// ===== tpwm_chan.sv
`timescale 1ns/1ps
`default_nettype none
// Output stage of one compare channel: rollover toggle and compare action.
module tpwm_chan (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic on,
   input wire logic hit,
   input wire logic wrap,
   input wire logic tor,
   input wire logic full,
   input wire logic [1:0] act,
   output logic level
);
   typedef struct packed {
      logic lvl;
   } chan_state_type;

   chan_state_type s_r;
   chan_state_type s_nxt;

   assign level = s_r.lvl;

   // The rollover toggle is applied first so that a compare in the same
   // tick wins; a compare value of zero thus gives a zero-width pulse.
   always_comb begin
      s_nxt = s_r;
      if (on && full && tor) begin
         s_nxt.lvl = (act != tpwm_pkg::ACT_SET);
      end else if (on) begin
         if (wrap && tor) begin
            s_nxt.lvl = !s_nxt.lvl;
         end
         if (hit) begin
            case (act)
               tpwm_pkg::ACT_CLEAR: s_nxt.lvl = 1'b0;
               tpwm_pkg::ACT_SET: s_nxt.lvl = 1'b1;
               tpwm_pkg::ACT_TOGGLE: s_nxt.lvl = !s_nxt.lvl;
               default: s_nxt.lvl = s_nxt.lvl;
            endcase
         end
      end
   end

   // Registers the pin level.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end
endmodule
`default_nettype wire

// ===== timer_buffered_compare_pwm.sv
// Overview of operation
// - Link-select bit joins channels 0 and 1; output on the channel 0 pin.
// - After linking, channel 0 compare value drives the output first.
// - Channel 1 write while linked takes over only at the next rollover.
// - At each linked rollover, the most recently written pair becomes active.
// - Linked: channel 0 control governs; channel 1 control has no effect.
// - Linked: the channel 1 pin is released for general-purpose use.
// - Writing the active pair takes effect at once, like unbuffered compare.
// - Toggle-on-rollover flips the output at each rollover, setting the period.
// - Pulse width runs from rollover to compare, where the action applies.
// - Limit 255 and prescaler code zero give a 256-clock period.
// - In a 256-count period, compare 128 gives 50 percent duty.
// - Buffered width update changes the pulse only from the next period.
// - Unsynchronised unbuffered writes may miss compares for one period.
// - Compare request ends the pulse; rollover request ends the period.
// - Mode field 0:1 is unbuffered compare, 1:0 buffered compare.
// - Action field 1:0 clears on compare, 1:1 sets on compare.
// - Channel 0 upper mode bit overrides the lower mode bit.
// - Without rollover toggle, compares hold the level: zero duty.
// - Counter reaching the limit sets the rollover flag and restarts at zero.
// - A compare match sets the channel flag and may request an interrupt.
// - Full-duty force with rollover toggle holds the output at full duty.
//
// Design decisions made here: register access over APB and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module timer_buffered_compare_pwm (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [7:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   output logic chan0_pin_o,
   output logic chan0_pin_oe,
   output logic chan1_pin_o,
   output logic chan1_pin_oe,
   output logic rollover_irq,
   output logic chan0_irq,
   output logic chan1_irq
);
   ////////////////////////////////////////////////////////////////////////
   typedef struct packed {
      logic [15:0] count;
      logic [15:0] period;
      logic halt;
      logic [2:0] ps;
      logic toie;
      logic rollover_flag;
      logic [7:0] c0ctrl;
      logic [7:0] c1ctrl;
      logic [15:0] cmp0;
      logic [15:0] cmp1;
      logic active;
      logic last_wr;
      logic [31:0] rdata;
      logic rerr;
   } state_type;

   localparam state_type STATE_RST = '{
      count: tpwm_pkg::COUNT_RST,
      period: tpwm_pkg::PERIOD_RST,
      halt: 1'b1,
      default: '0
   };

   state_type s_r;
   state_type s_nxt;
   logic setup;
   logic wr;
   logic link;
   logic [1:0] mode0;
   logic [1:0] mode1;
   logic on0;
   logic on1;
   logic clr;
   logic tick;
   logic wrap;
   logic [15:0] cnt_step;
   logic [15:0] cmp_act;
   logic hit0;
   logic hit1;
   logic lvl0;
   logic lvl1;
   logic pending;

   ////////////////////////////////////////////////////////////////////////
   // APB phases; the slave answers with no wait states.
   assign setup = psel && !penable;
   assign pready = psel && penable;
   assign wr = pready && pwrite;
   assign prdata = s_r.rdata;
   assign pslverr = s_r.rerr;

   // Mode decode of both channels.
   assign mode0 = s_r.c0ctrl[tpwm_pkg::MODE_LSB +: 2];
   assign mode1 = s_r.c1ctrl[tpwm_pkg::MODE_LSB +: 2];
   assign link = mode0[1];
   assign on0 = (mode0 != tpwm_pkg::MODE_OFF);
   assign on1 = !link && (mode1 != tpwm_pkg::MODE_OFF);

   // A set reset bit clears both counter and prescaler in that cycle.
   assign clr = wr && (paddr == tpwm_pkg::TCTRL_OFS)
                && pwdata[tpwm_pkg::CLR_BIT];

   assign wrap = tick && (s_r.count == s_r.period);
   assign cnt_step = wrap ? 16'h0000 : s_r.count + 16'h0001;

   assign cmp_act = (link && s_r.active) ? s_r.cmp1 : s_r.cmp0;

   // Compares fire on the tick at which the counter takes the value.
   // match ends the pulse
   assign hit0 = tick && on0 && (cnt_step == cmp_act);
   assign hit1 = tick && on1 && (cnt_step == s_r.cmp1);

   assign pending = s_r.last_wr ^ s_r.active;

   ////////////////////////////////////////////////////////////////////////
   // prescaler code zero ticks every clock
   tpwm_prescale #(
      .PRE_W(6)
   ) u_pre (
      .pclk(pclk),
      .presetn(presetn),
      .halt(s_r.halt),
      .clear(clr),
      .sel(s_r.ps),
      .tick(tick)
   );

   // Channel 0 stage, also the linked buffered output.
   tpwm_chan u_ch0 (
      .pclk(pclk),
      .presetn(presetn),
      .on(on0),
      .hit(hit0),
      .wrap(wrap),
      .tor(s_r.c0ctrl[tpwm_pkg::TOR_BIT]),
      .full(s_r.c0ctrl[tpwm_pkg::FULL_BIT]),
      .act(s_r.c0ctrl[tpwm_pkg::ACT_LSB +: 2]),
      .level(lvl0)
   );

   // Channel 1 stage, idle while linked.
   tpwm_chan u_ch1 (
      .pclk(pclk),
      .presetn(presetn),
      .on(on1),
      .hit(hit1),
      .wrap(wrap),
      .tor(s_r.c1ctrl[tpwm_pkg::TOR_BIT]),
      .full(s_r.c1ctrl[tpwm_pkg::FULL_BIT]),
      .act(s_r.c1ctrl[tpwm_pkg::ACT_LSB +: 2]),
      .level(lvl1)
   );

   ////////////////////////////////////////////////////////////////////////
   // Pins and interrupt requests.
   assign chan0_pin_o = lvl0;
   assign chan0_pin_oe = on0;
   assign chan1_pin_o = lvl1;
   assign chan1_pin_oe = on1;
   assign rollover_irq = s_r.rollover_flag && s_r.toie;
   assign chan0_irq = s_r.c0ctrl[tpwm_pkg::CHF_BIT]
                      && s_r.c0ctrl[tpwm_pkg::CIE_BIT];
   assign chan1_irq = !link && s_r.c1ctrl[tpwm_pkg::CHF_BIT]
                      && s_r.c1ctrl[tpwm_pkg::CIE_BIT];

   ////////////////////////////////////////////////////////////////////////
   // Next state: counter, pair pointer, bus reads and writes, event flags.
   always_comb begin
      s_nxt = s_r;
      if (clr) begin
         s_nxt.count = 16'h0000;
      end else if (tick) begin
         s_nxt.count = cnt_step;
      end
      if (!link) begin
         s_nxt.active = 1'b0;
         s_nxt.last_wr = 1'b0;
      end else if (wrap) begin
         s_nxt.active = s_r.last_wr;
      end
      // Read data and error are captured in the setup cycle.
      if (setup) begin
         s_nxt.rdata = 32'h0000_0000;
         s_nxt.rerr = 1'b0;
         if (paddr == tpwm_pkg::TCTRL_OFS) begin
            s_nxt.rdata[tpwm_pkg::HALT_BIT] = s_r.halt;
            s_nxt.rdata[tpwm_pkg::PS_LSB +: 3] = s_r.ps;
            s_nxt.rdata[tpwm_pkg::TOIE_BIT] = s_r.toie;
            s_nxt.rdata[tpwm_pkg::TOF_BIT] = s_r.rollover_flag;
         end else if (paddr == tpwm_pkg::COUNT_OFS) begin
            s_nxt.rdata[15:0] = s_r.count;
         end else if (paddr == tpwm_pkg::PERIOD_OFS) begin
            s_nxt.rdata[15:0] = s_r.period;
         end else if (paddr == tpwm_pkg::C0CTRL_OFS) begin
            s_nxt.rdata[7:0] = s_r.c0ctrl;
         end else if (paddr == tpwm_pkg::C0CMP_OFS) begin
            s_nxt.rdata[15:0] = s_r.cmp0;
         end else if (paddr == tpwm_pkg::C1CTRL_OFS) begin
            s_nxt.rdata[7:0] = s_r.c1ctrl;
         end else if (paddr == tpwm_pkg::C1CMP_OFS) begin
            s_nxt.rdata[15:0] = s_r.cmp1;
         end else if (paddr == tpwm_pkg::LINK_OFS) begin
            s_nxt.rdata[1:0] = {pending, s_r.active};
         end else begin
            s_nxt.rerr = 1'b1;
         end
      end
      // Writes take effect in the access cycle; flags clear on a written 0.
      if (wr) begin
         if (paddr == tpwm_pkg::TCTRL_OFS) begin
            s_nxt.halt = pwdata[tpwm_pkg::HALT_BIT];
            s_nxt.ps = pwdata[tpwm_pkg::PS_LSB +: 3];
            s_nxt.toie = pwdata[tpwm_pkg::TOIE_BIT];
            if (!pwdata[tpwm_pkg::TOF_BIT]) begin
               s_nxt.rollover_flag = 1'b0;
            end
         end else if (paddr == tpwm_pkg::PERIOD_OFS) begin
            s_nxt.period = pwdata[15:0];
         end else if (paddr == tpwm_pkg::C0CTRL_OFS) begin
            s_nxt.c0ctrl[6:0] = pwdata[6:0];
            if (!pwdata[tpwm_pkg::CHF_BIT]) begin
               s_nxt.c0ctrl[tpwm_pkg::CHF_BIT] = 1'b0;
            end
         end else if (paddr == tpwm_pkg::C0CMP_OFS) begin
            s_nxt.cmp0 = pwdata[15:0];
            if (link) begin
               s_nxt.last_wr = 1'b0;
            end
         end else if (paddr == tpwm_pkg::C1CTRL_OFS) begin
            s_nxt.c1ctrl[6:0] = pwdata[6:0];
            if (!pwdata[tpwm_pkg::CHF_BIT]) begin
               s_nxt.c1ctrl[tpwm_pkg::CHF_BIT] = 1'b0;
            end
         end else if (paddr == tpwm_pkg::C1CMP_OFS) begin
            s_nxt.cmp1 = pwdata[15:0];
            if (link) begin
               s_nxt.last_wr = 1'b1;
            end
         end
      end
      if (wrap) begin
         s_nxt.rollover_flag = 1'b1;
      end
      if (hit0) begin
         s_nxt.c0ctrl[tpwm_pkg::CHF_BIT] = 1'b1;
      end
      if (hit1) begin
         s_nxt.c1ctrl[tpwm_pkg::CHF_BIT] = 1'b1;
      end
   end

   // Registers the whole state.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s_r <= STATE_RST;
      end else begin
         s_r <= s_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Checks on the block's own behaviour.
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   logic tor0;
   logic full0;
   logic [1:0] act0;
   assign tor0 = s_r.c0ctrl[tpwm_pkg::TOR_BIT];
   assign full0 = s_r.c0ctrl[tpwm_pkg::FULL_BIT];
   assign act0 = s_r.c0ctrl[tpwm_pkg::ACT_LSB +: 2];

   sequence c1_write_s;
      wr && (paddr == tpwm_pkg::C1CMP_OFS);
   endsequence

   sequence queued_s;
      c1_write_s ##0 (link && !s_r.active && !wrap);
   endsequence

   rollover_restart_a: assert property (
      wrap && !clr |=> (s_r.count == 16'h0000) && s_r.rollover_flag)
      else $error("Rollover did not restart the counter and set the flag.");

   pin1_release_a: assert property (
      link |-> !chan1_pin_oe && !chan1_irq)
      else $error("Channel 1 pin still driven while linked.");

   buffered_defer_a: assert property (
      queued_s |=> !s_r.active && pending)
      else $error("Channel 1 write took effect before rollover.");

   pair_swap_a: assert property (
      link && wrap && !($past(!link)) |=> s_r.active == $past(s_r.last_wr))
      else $error("Active pair did not follow the last written pair.");

   active_write_a: assert property (
      wr && (paddr == tpwm_pkg::C0CMP_OFS) && link && !s_r.active && !wrap
      |=> cmp_act == $past(pwdata[15:0]))
      else $error("Write to the active pair was deferred.");

   zero_duty_a: assert property (
      on0 && !tor0 && (act0 == tpwm_pkg::ACT_CLEAR) && !lvl0
      ##1 (on0 && !tor0 && !full0) |-> !lvl0)
      else $error("Output left zero duty without rollover toggling.");

   full_duty_a: assert property (
      on0 && full0 && tor0 && (act0 == tpwm_pkg::ACT_CLEAR) |=> lvl0)
      else $error("Full-duty force did not hold the output high.");

   compare_clear_a: assert property (
      hit0 && !(full0 && tor0) && (act0 == tpwm_pkg::ACT_CLEAR) |=> !lvl0)
      else $error("Clear-on-compare did not clear the output.");

   rollover_toggle_a: assert property (
      wrap && on0 && tor0 && !full0 && !hit0 |=> lvl0 != $past(lvl0))
      else $error("Output did not toggle at rollover.");

   chan_flag_a: assert property (
      hit0 |=> s_r.c0ctrl[tpwm_pkg::CHF_BIT]
      ##0 chan0_irq == s_r.c0ctrl[tpwm_pkg::CIE_BIT])
      else $error("Compare match did not set the channel flag.");

   full_rate_a: assert property (
      (s_r.ps == 3'h0) && !s_r.halt && !clr |-> tick)
      else $error("Prescaler code zero did not tick every clock.");
endmodule
`default_nettype wire

// ===== testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
   logic pclk, presetn, psel, penable, pwrite;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic pready, pslverr, c0_o, c0_oe, c1_o, c1_oe, ro_irq, c0_irq, c1_irq;
   int num_errors = 0;
   int checks_done = 0;

   ////////////////////////////////////////////////////////////////////////
   // Design under test, driven straight from the bench.
   timer_buffered_compare_pwm timer_buffered_compare_pwm_inst (
      .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
      .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .chan0_pin_o(c0_o), .chan0_pin_oe(c0_oe), .chan1_pin_o(c1_o),
      .chan1_pin_oe(c1_oe), .rollover_irq(ro_irq), .chan0_irq(c0_irq),
      .chan1_irq(c1_irq));

   // Clock of 10 ns period.
   always #5 pclk = ~pclk;

   ////////////////////////////////////////////////////////////////////////
   // Compares one value and counts the outcome.
   task automatic check(input string name, input logic [31:0] seen,
                        input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         num_errors++;
         $display("MISMATCH %s expected %h seen %h", name, exp, seen);
      end
   endtask

   // Prints the counts and the verdict, then stops the run.
   task automatic test_done();
      $display("checks %0d mismatches %0d", checks_done, num_errors);
      if (num_errors == 0 && checks_done > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   // One APB transfer; holds the request until pready is seen high.
   task automatic apb(input logic wr, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] q,
                      output logic err);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) begin
         @(posedge pclk);
      end
      q = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      logic e;
      apb(1'b1, a, d, q, e);
   endtask

   task automatic rdw(input logic [7:0] a, output logic [31:0] q);
      logic e;
      apb(1'b0, a, 32'h0, q, e);
   endtask

   // Counts high cycles and rising edges of the channel 0 pin over n cycles.
   task automatic duty(input int n, output int h, output int r);
      logic p;
      h = 0;
      r = 0;
      @(negedge pclk);
      p = c0_o;
      repeat (n) begin
         @(negedge pclk);
         if (c0_o === 1'b1) h++;
         if (c0_o === 1'b1 && p === 1'b0) r++;
         p = c0_o;
      end
   endtask

   // Follows the safe start-up order, then measures two 256-tick periods.
   // no scenario uses the toggle compare action for PWM.
   // widths change only while halted, so no compare is missed.
   task automatic pwm_run(input string name, input logic [31:0] ctl,
                          input logic [31:0] cmp, input int eh,
                          input int er);
      int h, r;
      // halt and clear, limit, compare, channel, then release.
      wr(tpwm_pkg::TCTRL_OFS, 32'h0000_0003);
      rdw(tpwm_pkg::COUNT_OFS, rd);
      check({name, " count"}, rd, 32'h0);
      wr(tpwm_pkg::PERIOD_OFS, 32'h0000_00FF);
      wr(tpwm_pkg::C0CMP_OFS, cmp);
      wr(tpwm_pkg::C0CTRL_OFS, ctl);
      wr(tpwm_pkg::TCTRL_OFS, 32'h0000_0000);
      repeat (300) @(posedge pclk);
      duty(512, h, r);
      check({name, " high"}, h, eh);
      check({name, " rises"}, r, er);
      check({name, " oe"}, c0_oe, 1'b1);
      $display("test %s done", name);
   endtask

   ////////////////////////////////////////////////////////////////////////
   // Watchdog against a hang.
   initial begin
      repeat (40000) @(posedge pclk);
      num_errors++;
      test_done();
   end

   // Main test sequence.
   initial begin
      logic e;
      pclk = 1'b0;
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      // Reset values and an unmapped address.
      rdw(tpwm_pkg::TCTRL_OFS, rd);
      check("ctrl reset", rd, 32'h0000_0001);
      rdw(tpwm_pkg::PERIOD_OFS, rd);
      check("limit reset", rd, 32'h0000_FFFF);
      check("pin oe off", c0_oe, 1'b0);
      apb(1'b0, 8'h20, 32'h0, rd, e);
      check("unmapped err", e, 1'b1);
      check("unmapped data", rd, 32'h0);
      $display("test reset done");
      pwm_run("half", 32'h0000_0019, 32'h0000_0080, 256, 2);
      rdw(tpwm_pkg::TCTRL_OFS, rd);
      check("rollover flag", rd & 32'h81, 32'h80);
      rdw(tpwm_pkg::C0CTRL_OFS, rd);
      check("compare flag", rd & 32'h80, 32'h80);
      wr(tpwm_pkg::TCTRL_OFS, 32'h0000_0040);
      wr(tpwm_pkg::C0CTRL_OFS, 32'h0000_00D9);
      repeat (300) @(posedge pclk);
      check("rollover irq", ro_irq, 1'b1);
      check("compare irq", c0_irq, 1'b1);
      $display("test flags done");
      pwm_run("clear64", 32'h0000_0019, 32'h0000_0040, 128, 2);
      pwm_run("set64", 32'h0000_001D, 32'h0000_0040, 384, 2);
      pwm_run("zero", 32'h0000_0018, 32'h0000_0080, 0, 0);
      pwm_run("full", 32'h0000_001B, 32'h0000_0080, 512, 0);
      // linked with both mode bits set.
      pwm_run("linked", 32'h0000_0039, 32'h0000_0080, 256, 2);
      rdw(tpwm_pkg::LINK_OFS, rd);
      check("link start", rd, 32'h0);
      check("ch1 pin freed", c1_oe, 1'b0);
      // channel 1 control ignored while linked.
      wr(tpwm_pkg::C1CTRL_OFS, 32'h0000_0050);
      repeat (300) @(posedge pclk);
      check("ch1 oe", c1_oe, 1'b0);
      check("ch1 irq", c1_irq, 1'b0);
      check("ch1 level", c1_o, 1'b0);
      // queued write to the inactive pair.
      wr(tpwm_pkg::C1CMP_OFS, 32'h0000_0040);
      rdw(tpwm_pkg::LINK_OFS, rd);
      check("pending set", rd, 32'h2);
      repeat (300) @(posedge pclk);
      rdw(tpwm_pkg::LINK_OFS, rd);
      check("swap to ch1", rd, 32'h1);
      repeat (512) @(negedge pclk);
      begin
         int h, r;
         duty(512, h, r);
         check("ch1 width", h, 128);
      end
      // write to the active pair is not queued.
      wr(tpwm_pkg::C1CMP_OFS, 32'h0000_0060);
      rdw(tpwm_pkg::LINK_OFS, rd);
      check("no pending", rd, 32'h1);
      // back to channel 0 at the next rollover.
      wr(tpwm_pkg::C0CMP_OFS, 32'h0000_00C0);
      rdw(tpwm_pkg::LINK_OFS, rd);
      check("pending ch0", rd, 32'h3);
      repeat (300) @(posedge pclk);
      rdw(tpwm_pkg::LINK_OFS, rd);
      check("swap to ch0", rd, 32'h0);
      begin
         int h, r;
         duty(512, h, r);
         check("ch0 width", h, 384);
      end
      $display("test linked done");
      // Prescaler code one: the counter advances every second clock.
      wr(tpwm_pkg::TCTRL_OFS, 32'h0000_0003);
      wr(tpwm_pkg::TCTRL_OFS, 32'h0000_0004);
      repeat (100) @(posedge pclk);
      rdw(tpwm_pkg::COUNT_OFS, rd);
      check("half rate count", rd, 32'h0000_0032);
      $display("test prescale done");
      test_done();
   end
endmodule
`default_nettype wire
